// ===== sbsi_bus_checker.sv
/*
 Concurrent checks on the bus between the burst SRAM and its controller.
 Assumes the testbench instantiates it beside the interface, signals connected by name.
*/
`timescale 1ns/1ps
`default_nettype none
module sbsi_bus_checker #(
   parameter int LANES = 4
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic controller_addr_strobe_n,
   input wire logic processor_addr_strobe_n,
   input wire logic chip_sel_first_n,
   input wire logic chip_sel_second,
   input wire logic chip_sel_third_n,
   input wire logic global_write_n,
   input wire logic byte_write_enable_n,
   input wire logic [LANES-1:0] byte_lane_select_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic dq_host_oe,
   input wire logic dq_dev_oe
);
   logic sel;
   logic wdec;
   logic wr_start;
   logic rd_start;
   logic desel;
   logic quiet;
   logic bus_idle;
   logic fresh_q;
   assign sel = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
   assign wdec = !global_write_n || (!byte_write_enable_n && !(&byte_lane_select_n));
   assign wr_start = !controller_addr_strobe_n && processor_addr_strobe_n && sel && wdec && !sleep_request;
   assign rd_start = sel && !sleep_request && (!processor_addr_strobe_n || (!controller_addr_strobe_n && !wdec));
   assign desel = (chip_sel_first_n && !controller_addr_strobe_n) || (!processor_addr_strobe_n && !chip_sel_first_n && !sel)
      || (!controller_addr_strobe_n && (!chip_sel_second || chip_sel_third_n));
   assign quiet = controller_addr_strobe_n && processor_addr_strobe_n && !output_enable_n && !sleep_request;
   assign bus_idle = controller_addr_strobe_n && processor_addr_strobe_n && chip_sel_first_n && !chip_sel_second
      && chip_sel_third_n;
   // Set while the device has been deselected, reset or put to sleep since its last start
   always_ff @(posedge clock_i) begin
      if (!rst_b_i || desel || sleep_request) begin
         fresh_q <= 1'b1;
      end else if (rd_start || wr_start) begin
         fresh_q <= 1'b0;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_desel_read;
      fresh_q && rd_start;
   endsequence
   // Two quiet cycles cover the extra tristate cycle after a deselect
   sequence s_read_held;
      rd_start ##1 quiet [*2];
   endsequence
   property p_wr_tristate;
      wr_start |=> !dq_dev_oe;
   endproperty
   a_wr_tristate: assert property (p_wr_tristate) else $error("data pins driven after a write start");
   property p_oe_mask;
      dq_dev_oe |-> !output_enable_n;
   endproperty
   a_oe_mask: assert property (p_oe_mask) else $error("data pins driven with output enable high");
   property p_desel;
      desel |=> !dq_dev_oe;
   endproperty
   a_desel: assert property (p_desel) else $error("data pins driven after a deselect");
   property p_first_cycle;
      s_desel_read |=> !dq_dev_oe;
   endproperty
   a_first_cycle: assert property (p_first_cycle) else $error("first read cycle after deselect driven");
   property p_read_drive;
      s_read_held |-> dq_dev_oe;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read data not driven");
   property p_sleep_tristate;
      sleep_request [*3] |-> !dq_dev_oe;
   endproperty
   a_sleep_tristate: assert property (p_sleep_tristate) else $error("data pins driven in sleep");
   property p_host_oe;
      dq_host_oe |-> output_enable_n;
   endproperty
   a_host_oe: assert property (p_host_oe) else $error("host drives data with output enable low");
   property p_sleep_entry;
      $rose(sleep_request) |-> bus_idle && $past(desel);
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep raised while selected");
   property p_wake_idle;
      $fell(sleep_request) |-> bus_idle [*2];
   endproperty
   a_wake_idle: assert property (p_wake_idle) else $error("bus active during sleep recovery");
endmodule
`default_nettype wire

// ===== sbsi_bus_if.sv
/*
 Synchronous bus between the pipelined burst SRAM and its controller.
 Data pins are split into host and device vectors, each with its own enable; nothing resolves them.
*/
`timescale 1ns/1ps
`default_nettype none
interface sbsi_bus_if #(parameter int AW = 18, parameter int LANES = 4, parameter int LW = 9);
   logic [AW-1:0] addr;
   logic controller_addr_strobe_n;
   logic processor_addr_strobe_n;
   logic burst_advance_n;
   logic chip_sel_first_n;
   logic chip_sel_second;
   logic chip_sel_third_n;
   logic global_write_n;
   logic byte_write_enable_n;
   logic [LANES-1:0] byte_lane_select_n;
   logic output_enable_n;
   logic sleep_request;
   logic burst_order;
   logic [LANES*LW-1:0] dq_host;
   logic dq_host_oe;
   logic [LANES*LW-1:0] dq_dev;
   logic dq_dev_oe;

   modport dev (input addr, controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n,
                chip_sel_first_n, chip_sel_second, chip_sel_third_n, global_write_n,
                byte_write_enable_n, byte_lane_select_n, output_enable_n, sleep_request,
                burst_order, dq_host, dq_host_oe, output dq_dev, dq_dev_oe);
   modport host (output addr, controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n,
                 chip_sel_first_n, chip_sel_second, chip_sel_third_n, global_write_n,
                 byte_write_enable_n, byte_lane_select_n, output_enable_n, sleep_request,
                 burst_order, dq_host, dq_host_oe, input dq_dev, dq_dev_oe);
endinterface
`default_nettype wire

// ===== sbsi_ctrl_host.sv
/*
 Controller end: turns simple user requests into strobe sequences for the SRAM.
 Assumes one request at a time; accesses are single beats with advance held high, reads return after two clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sbsi_ctrl_host
   import sbsi_pkg::*;
#(
   parameter int AW = 18,
   parameter int LANES = 4,
   parameter int LW = 9
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   sbsi_bus_if.host bus,
   input wire logic req_i,
   input wire logic req_write_i,
   input wire logic [AW-1:0] req_addr_i,
   input wire logic [LANES*LW-1:0] req_wdata_i,
   input wire logic [LANES-1:0] req_lane_n_i,
   input wire logic sleep_i,
   input wire logic order_i,
   output logic ready_o,
   output logic rvalid_o,
   output logic [LANES*LW-1:0] rdata_o
);
   typedef enum logic [2:0] {
      SBSI_H_IDLE = 3'b000,
      SBSI_H_WR = 3'b001,
      SBSI_H_RD = 3'b010,
      SBSI_H_RD2 = 3'b011,
      SBSI_H_REC = 3'b100,
      SBSI_H_DSL = 3'b101
   } sbsi_host_e;

   sbsi_host_e st_q, st_d;
   logic [1:0] cnt_q, cnt_d;
   logic sleep_q, sleep_d;
   logic rvalid_q, rvalid_d;
   logic [LANES*LW-1:0] rdata_q, rdata_d;
   logic [AW-1:0] addr_q, addr_d;
   logic [LANES*LW-1:0] wdata_q, wdata_d;
   logic [LANES-1:0] lane_q, lane_d;
   logic wr_q, wr_d;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sleep_d = sleep_q;
      rvalid_d = 1'b0;
      rdata_d = rdata_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      lane_d = lane_q;
      wr_d = 1'b0;
      unique case (st_q)
         SBSI_H_IDLE: begin
            if (sleep_i != sleep_q) begin
               if (sleep_i) begin
                  // Idle leaves the device in a suspended burst, so deselect it first
                  st_d = SBSI_H_DSL;
               end else begin
                  sleep_d = 1'b0;
                  st_d = SBSI_H_REC;
                  cnt_d = 2'(SBSI_SLEEP_RECOVERY_CYCLES);
               end
            end else if (req_i && !sleep_q) begin
               addr_d = req_addr_i;
               wdata_d = req_wdata_i;
               lane_d = req_lane_n_i;
               wr_d = req_write_i;
               st_d = req_write_i ? SBSI_H_WR : SBSI_H_RD;
               cnt_d = 2'h2;
            end
         end
         SBSI_H_WR: begin
            st_d = SBSI_H_IDLE;
         end
         SBSI_H_RD: begin
            st_d = SBSI_H_RD2;
         end
         SBSI_H_RD2: begin
            // Wait out the output register plus first-cycle tristate
            cnt_d = 2'(cnt_q - 2'h1);
            if (cnt_q == 2'h1) begin
               rvalid_d = 1'b1;
               rdata_d = bus.dq_dev;
               st_d = SBSI_H_IDLE;
            end
         end
         SBSI_H_REC: begin
            cnt_d = 2'(cnt_q - 2'h1);
            if (cnt_q == 2'h1) begin
               st_d = SBSI_H_IDLE;
            end
         end
         SBSI_H_DSL: begin
            sleep_d = 1'b1;
            st_d = SBSI_H_IDLE;
         end
         default: st_d = SBSI_H_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         st_q <= SBSI_H_IDLE;
         cnt_q <= 2'h0;
         sleep_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         addr_q <= '0;
         wdata_q <= '0;
         lane_q <= '1;
         wr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sleep_q <= sleep_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         lane_q <= lane_d;
         wr_q <= wr_d;
      end
   end

   // Controller strobe start for both reads and single-cycle writes
   assign bus.addr = addr_q;
   assign bus.controller_addr_strobe_n = ~(st_q == SBSI_H_WR || st_q == SBSI_H_RD || st_q == SBSI_H_DSL);
   assign bus.processor_addr_strobe_n = 1'b1;
   assign bus.burst_advance_n = 1'b1;
   assign bus.chip_sel_first_n = ~(st_q == SBSI_H_WR || st_q == SBSI_H_RD);
   assign bus.chip_sel_second = (st_q == SBSI_H_WR || st_q == SBSI_H_RD);
   assign bus.chip_sel_third_n = ~(st_q == SBSI_H_WR || st_q == SBSI_H_RD);
   assign bus.global_write_n = 1'b1;
   assign bus.byte_write_enable_n = ~(st_q == SBSI_H_WR);
   assign bus.byte_lane_select_n = (st_q == SBSI_H_WR) ? lane_q : '1;
   // Output enable held high through writes so the pins never fight
   assign bus.output_enable_n = ~(st_q == SBSI_H_RD || st_q == SBSI_H_RD2) | (st_q == SBSI_H_WR);
   assign bus.dq_host = wdata_q;
   assign bus.dq_host_oe = (st_q == SBSI_H_WR) & bus.output_enable_n;
   assign bus.sleep_request = sleep_q;
   assign bus.burst_order = order_i;
   assign ready_o = (st_q == SBSI_H_IDLE) & ~sleep_q & (sleep_i == sleep_q);
   assign rvalid_o = rvalid_q;
   assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// ===== sbsi_pkg.sv
/*
 Package for the synchronous burst SRAM front end: clock period, burst order codes,
 sleep timing constants and the access-phase enumeration.
 Assumes a single 100 MHz clock shared by both ends.
*/
package sbsi_pkg;
   localparam int SBSI_CLK_PERIOD_NS = 10;
   localparam int SBSI_SLEEP_RECOVERY_TIME_CYC = 2;
   localparam int SBSI_SLEEP_RECOVERY_CYCLES = SBSI_SLEEP_RECOVERY_TIME_CYC;
   localparam int SBSI_SLEEP_SYNC_STAGES = 2;
   localparam logic [1:0] SBSI_LOW_ADDR_RESET = 2'h0;
   localparam logic SBSI_ORDER_LINEAR = 1'h0;
   localparam logic SBSI_ORDER_INTERLEAVED = 1'h1;

   typedef enum logic [1:0] {
      SBSI_PH_IDLE = 2'b00,
      SBSI_PH_READ = 2'b01,
      SBSI_PH_WRITE = 2'b10
   } sbsi_phase_e;

   function automatic logic [1:0] sbsi_next_low(input logic [1:0] cur, input logic [1:0] start,
                                                input logic order);
      logic [1:0] step;
      step = 2'((cur ^ start) + 2'h1);
      if (order == SBSI_ORDER_INTERLEAVED) begin
         sbsi_next_low = start ^ step;
      end else begin
         sbsi_next_low = 2'(cur + 2'h1);
      end
   endfunction
endpackage

// ===== sbsi_sram_dev.sv
/*
 Device end: pipelined burst SRAM with address register, two-bit burst counter,
 byte writes, registered read data and synchronized sleep.
 Assumes the controller keeps its own bus rules; the array has no reset.
*/
// Functional notes
// - Controller strobe write completes in one cycle
// - Controller start loads address, ignores advance
// - Global writes all lanes, byte writes selected
// - Data pins released whenever a write detected; code skips this when a deselect comes in the same cycle
// - Master raises output enable before driving data
// - Two-bit wrap counter, strap picks order
// - Strap high gives interleaved burst order
// - Strap low gives linear wrap order
// - Advance low steps counter, reads and writes
// - No start, advance low continues burst
// - No start, advance high repeats current address
// - Selects ignored in continue; write ignores enable
// - Three deselect cases tristate data pins
// - Selected processor strobe always starts read
// - Writes only after processor start or controller
// - Write decode from global and byte enables
// - Output enable asynchronous, masked during writes
// - Sleep tristates pins, two cycles in/out
// - Array kept while asleep, pending accesses lost
// - Master deselects before sleep, waits recovery
// - Read data registered, first cycle tristated
// - Processor write samples data second clock
`timescale 1ns/1ps
`default_nettype none
module sbsi_sram_dev
   import sbsi_pkg::*;
#(
   parameter int AW = 18,
   parameter int LANES = 4,
   parameter int LW = 9
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   sbsi_bus_if.dev bus,
   output logic asleep_o,
   output logic [AW-1:0] cur_addr_o
);
   localparam int DW = LANES * LW;

   logic [DW-1:0] mem [0:(1<<AW)-1];

   logic [AW-1:0] addr_q, addr_d;
   logic [1:0] start_low_q, start_low_d;
   sbsi_phase_e phase_q, phase_d;
   logic selected_q, selected_d;
   logic first_q, first_d;
   logic [DW-1:0] rdata_q, rdata_d;
   logic sleep_s1_q, sleep_s2_q;

   logic write_dec;
   logic sel_all;
   logic proc_start, ctrl_start, deselect, any_begin;
   logic [AW-1:0] acc_addr;
   logic do_write, do_read;
   logic [LANES-1:0] lane_we;

   // Only the second flop is read; the sleep pin is asynchronous
   always_ff @(posedge clock_i) begin
      sleep_s1_q <= bus.sleep_request;
      sleep_s2_q <= sleep_s1_q;
   end

   always_comb begin
      write_dec = ~bus.global_write_n | (~bus.byte_write_enable_n & ~(&bus.byte_lane_select_n));
      sel_all = ~bus.chip_sel_first_n & bus.chip_sel_second & ~bus.chip_sel_third_n;
      proc_start = ~bus.processor_addr_strobe_n & ~bus.chip_sel_first_n & sel_all;
      ctrl_start = ~bus.controller_addr_strobe_n & bus.processor_addr_strobe_n & sel_all;
      deselect = (~bus.controller_addr_strobe_n & bus.chip_sel_first_n)
               | (~bus.processor_addr_strobe_n & ~bus.chip_sel_first_n & ~sel_all)
               | (~bus.controller_addr_strobe_n & (~bus.chip_sel_second | bus.chip_sel_third_n));
      any_begin = proc_start | ctrl_start;
      addr_d = addr_q;
      start_low_d = start_low_q;
      phase_d = phase_q;
      selected_d = selected_q;
      first_d = 1'b0;
      rdata_d = rdata_q;
      acc_addr = addr_q;
      do_write = 1'b0;
      do_read = 1'b0;
      lane_we = '0;
      if (sleep_s2_q || !rst_b_i) begin
         // Pending accesses are dropped; array contents stay
         phase_d = SBSI_PH_IDLE;
         selected_d = 1'b0;
      end else if (proc_start) begin
         addr_d = bus.addr;
         start_low_d = bus.addr[1:0];
         acc_addr = bus.addr;
         phase_d = SBSI_PH_READ;
         do_read = 1'b1;
         selected_d = 1'b1;
         first_d = ~selected_q;
      end else if (ctrl_start) begin
         addr_d = bus.addr;
         start_low_d = bus.addr[1:0];
         acc_addr = bus.addr;
         selected_d = 1'b1;
         first_d = ~selected_q;
         if (write_dec) begin
            phase_d = SBSI_PH_WRITE;
            do_write = 1'b1;
         end else begin
            phase_d = SBSI_PH_READ;
            do_read = 1'b1;
         end
      end else if (deselect) begin
         phase_d = SBSI_PH_IDLE;
         selected_d = 1'b0;
      end else if (selected_q) begin
         if (!bus.burst_advance_n) begin
            addr_d = {addr_q[AW-1:2], sbsi_next_low(addr_q[1:0], start_low_q, bus.burst_order)};
         end
         acc_addr = addr_d;
         // Selects are not looked at here
         phase_d = write_dec ? SBSI_PH_WRITE : SBSI_PH_READ;
         do_write = write_dec;
         do_read = ~write_dec;
      end
      if (do_write) begin
         lane_we = bus.global_write_n ? ~bus.byte_lane_select_n : {LANES{1'b1}};
      end
      if (do_read) begin
         rdata_d = mem[acc_addr];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         addr_q <= '0;
         start_low_q <= SBSI_LOW_ADDR_RESET;
         phase_q <= SBSI_PH_IDLE;
         selected_q <= 1'b0;
         first_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         addr_q <= addr_d;
         start_low_q <= start_low_d;
         phase_q <= phase_d;
         selected_q <= selected_d;
         first_q <= first_d;
         rdata_q <= rdata_d;
      end
   end

   // Lane-wise store so unselected lanes keep their contents
   always_ff @(posedge clock_i) begin
      for (int l = 0; l < LANES; l++) begin
         if (lane_we[l]) begin
            mem[acc_addr][l*LW +: LW] <= bus.dq_host[l*LW +: LW];
         end
      end
   end

   // Output enable is used combinationally, never sampled
   assign bus.dq_dev = rdata_q;
   assign bus.dq_dev_oe = (phase_q == SBSI_PH_READ) & ~first_q & ~bus.output_enable_n
                        & ~sleep_s2_q & ~(write_dec & ~deselect & selected_q);
   assign asleep_o = sleep_s2_q;
   assign cur_addr_o = addr_q;
endmodule
`default_nettype wire

// ===== sync_burst_sram_interface_test.sv
/*
 Testbench: controller and SRAM joined by the bus interface, driven from the user side.
 Assumes default widths; one request at a time through the controller.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_interface_test;
   localparam int AW = 18;
   localparam int LANES = 4;
   localparam int DW = 36;
   localparam int LIMIT = 3000;
   typedef struct packed {
      logic wr;
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
      logic [LANES-1:0] lane_n;
      logic [DW-1:0] exp;
   } sbsi_row_s;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic req = 1'b0;
   logic req_write = 1'b0;
   logic [AW-1:0] req_addr = '0;
   logic [DW-1:0] req_wdata = '0;
   logic [LANES-1:0] req_lane_n = '1;
   logic sleep_req = 1'b0;
   logic order = 1'b1;
   logic ready;
   logic rvalid;
   logic [DW-1:0] rdata;
   logic asleep;
   logic [AW-1:0] cur_addr;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   // Lane 1 of the byte write is bits 17:9; the other lanes must keep the earlier write made on all four byte lanes
   sbsi_row_s rows [7] = '{
      '{1'b1, 18'h00010, 36'h123456789, 4'h0, 36'h0},
      '{1'b0, 18'h00010, 36'h0, 4'h0, 36'h123456789},
      '{1'b1, 18'h00010, 36'hfffffffff, 4'hd, 36'h0},
      '{1'b0, 18'h00010, 36'h0, 4'h0, 36'h12347ff89},
      '{1'b1, 18'h3ffff, 36'h0aaaaaaaa, 4'h0, 36'h0},
      '{1'b0, 18'h3ffff, 36'h0, 4'h0, 36'h0aaaaaaaa},
      '{1'b0, 18'h00010, 36'h0, 4'h0, 36'h12347ff89}};
   // Expected burst orders per start value, four beats each
   logic [1:0] seq_il [16] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h0, 2'h3, 2'h2,
      2'h2, 2'h3, 2'h0, 2'h1, 2'h3, 2'h2, 2'h1, 2'h0};
   logic [1:0] seq_ln [16] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3, 2'h0,
      2'h2, 2'h3, 2'h0, 2'h1, 2'h3, 2'h0, 2'h1, 2'h2};
   sbsi_bus_if #(.AW(AW), .LANES(LANES), .LW(9)) bus ();
   sbsi_sram_dev #(.AW(AW), .LANES(LANES), .LW(9)) i_sbsi_sram_dev (.clock_i(clk), .rst_b_i(rst_b),
      .bus(bus.dev), .asleep_o(asleep), .cur_addr_o(cur_addr));
   sbsi_ctrl_host #(.AW(AW), .LANES(LANES), .LW(9)) i_sbsi_ctrl_host (.clock_i(clk), .rst_b_i(rst_b),
      .bus(bus.host), .req_i(req), .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
      .req_lane_n_i(req_lane_n), .sleep_i(sleep_req), .order_i(order), .ready_o(ready), .rvalid_o(rvalid),
      .rdata_o(rdata));
   sbsi_bus_checker #(.LANES(LANES)) i_sbsi_bus_checker (.clock_i(clk), .rst_b_i(rst_b),
      .controller_addr_strobe_n(bus.controller_addr_strobe_n), .processor_addr_strobe_n(bus.processor_addr_strobe_n),
      .chip_sel_first_n(bus.chip_sel_first_n), .chip_sel_second(bus.chip_sel_second),
      .chip_sel_third_n(bus.chip_sel_third_n), .global_write_n(bus.global_write_n),
      .byte_write_enable_n(bus.byte_write_enable_n), .byte_lane_select_n(bus.byte_lane_select_n),
      .output_enable_n(bus.output_enable_n), .sleep_request(bus.sleep_request), .dq_host_oe(bus.dq_host_oe),
      .dq_dev_oe(bus.dq_dev_oe));
   always #5 clk = ~clk;
   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         error_cnt++;
         $display("[ERR] run length expected below %0d seen %0d", LIMIT, cyc);
         end_sim();
      end
   end
   task automatic cmp_data(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cmp_flag(input string name, input logic exp, input logic got);
      cmp_data(name, DW'(exp), DW'(got));
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   // Waits on ready and on the read pulse; the pulse rises in the same cycle that ready returns
   task automatic host_op(input sbsi_row_s r);
      int n;
      logic seen;
      logic [DW-1:0] got;
      n = 0;
      seen = 1'b0;
      got = '0;
      while (ready !== 1'b1 && n < 20) begin
         step();
         n++;
      end
      req = 1'b1;
      req_write = r.wr;
      req_addr = r.addr;
      req_wdata = r.data;
      req_lane_n = r.lane_n;
      step();
      req = 1'b0;
      n = 0;
      do begin
         step();
         n++;
         if (rvalid === 1'b1) begin
            seen = 1'b1;
            got = rdata;
         end
      end while ((ready !== 1'b1 || (!r.wr && !seen)) && n < 20);
      cmp_flag("request done", 1'b1, ready);
      step();
      cmp_data("address register", DW'(r.addr), DW'(cur_addr));
      if (!r.wr) begin
         cmp_flag("read valid", 1'b1, seen);
         cmp_data("read data", r.exp, got);
      end
   endtask
   task automatic sleep_step(input logic lvl);
      int n;
      n = 0;
      sleep_req = lvl;
      while (bus.sleep_request !== lvl && n < 20) begin
         step();
         n++;
      end
      n = 0;
      while (asleep !== lvl && n < 8) begin
         step();
         n++;
      end
      cmp_data("sleep transition cycles", 36'h2, DW'(n));
   endtask
   initial begin
      logic [1:0] nxt;
      repeat (8) @(posedge clk);
      #1;
      rst_b = 1'b1;
      foreach (rows[i]) begin
         host_op(rows[i]);
      end
      // The controller never advances a burst, so the step function is held to the tables
      for (int s = 0; s < 4; s++) begin
         for (int b = 1; b < 4; b++) begin
            nxt = sbsi_pkg::sbsi_next_low(seq_il[s*4+b-1], 2'(s), 1'b1);
            cmp_data("interleaved burst step", DW'(seq_il[s*4+b]), DW'(nxt));
            nxt = sbsi_pkg::sbsi_next_low(seq_ln[s*4+b-1], 2'(s), 1'b0);
            cmp_data("linear burst step", DW'(seq_ln[s*4+b]), DW'(nxt));
         end
      end
      order = 1'b0;
      sleep_step(1'b1);
      repeat (3) step();
      cmp_flag("ready while asleep", 1'b0, ready);
      cmp_flag("device drive while asleep", 1'b0, bus.dq_dev_oe);
      sleep_step(1'b0);
      host_op(sbsi_row_s'{1'b0, 18'h3ffff, 36'h0, 4'h0, 36'h0aaaaaaaa});
      rst_b = 1'b0;
      repeat (8) step();
      rst_b = 1'b1;
      step();
      cmp_flag("device drive after reset", 1'b0, bus.dq_dev_oe);
      host_op(sbsi_row_s'{1'b0, 18'h00010, 36'h0, 4'h0, 36'h12347ff89});
      end_sim();
   end
endmodule
`default_nettype wire
